// file: smx_pkg.sv
// package with register map, field layout and switch types for the switch matrix
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
package smx_pkg;

    //------------------------------------------------------------------
    // register map
    //------------------------------------------------------------------
    localparam int SMX_ADDR_W = 16;
    localparam logic [SMX_ADDR_W-1:0] SMX_OFS_GROUP = 16'h2140;
    localparam logic [SMX_ADDR_W-1:0] SMX_OFS_DFULL = 16'h2150;

    //------------------------------------------------------------------
    // grouped register fields
    //------------------------------------------------------------------
    localparam int SMX_DCODE_LSB = 0;
    localparam int SMX_PCODE_LSB = 4;
    localparam int SMX_SRCSEL_BIT = 16;
    localparam logic [3:0] SMX_DCODE_RST = 4'hf;
    localparam logic [3:0] SMX_PCODE_RST = 4'hf;
    localparam logic SMX_SRCSEL_RST = 1'b0;

    //------------------------------------------------------------------
    // individual D register fields
    //------------------------------------------------------------------
    localparam logic [7:0] SMX_DFULL_RST = 8'h00;
    // bit 5 is reserved and holds no storage
    localparam logic [7:0] SMX_DFULL_MASK = 8'hdf;

    //------------------------------------------------------------------
    // group codes
    //------------------------------------------------------------------
    localparam logic [3:0] SMX_DCODE_OPEN = 4'h0;
    localparam logic [3:0] SMX_DCODE_CAL = 4'h1;
    localparam logic [3:0] SMX_DCODE_SW2 = 4'h2;
    localparam logic [3:0] SMX_DCODE_SW8 = 4'h8;
    localparam logic [3:0] SMX_DCODE_ALL = 4'h9;
    localparam logic [3:0] SMX_PCODE_SW5 = 4'h5;
    localparam logic [3:0] SMX_PCODE_SW9 = 4'h9;
    localparam logic [3:0] SMX_PCODE_SW11 = 4'hb;
    localparam logic [3:0] SMX_PCODE_LOOP_LO = 4'hd;
    localparam logic [3:0] SMX_PCODE_LOOP_HI = 4'he;

    //------------------------------------------------------------------
    // bus answers
    //------------------------------------------------------------------
    localparam logic [1:0] SMX_RESP_OKAY = 2'b00;
    localparam logic [1:0] SMX_RESP_DECERR = 2'b11;

    //------------------------------------------------------------------
    // switch enable carriers, 1 = closed
    //------------------------------------------------------------------
    typedef struct packed {
        logic eight;
        logic seven;
        logic six;
        logic five;
        logic four;
        logic three;
        logic two;
        logic calibration;
    } smx_dsw_t;

    typedef struct packed {
        logic loop_two;
        logic eleven;
        logic nine;
        logic eight;
        logic seven;
        logic six;
        logic five;
    } smx_psw_t;

endpackage

// file: smx_switch_drive.sv
// group code decoders and registered switch enable outputs
`timescale 1ns/1ps
module smx_switch_drive
    import smx_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic switch_source_select,
    input wire logic [3:0] dnode_group_code,
    input wire logic [3:0] pnode_group_code,
    input wire logic [7:0] d_individual,
    input wire logic [6:0] p_individual,
    output smx_dsw_t dnode_switch_group,
    output smx_psw_t pnode_switch_group
);

    //------------------------------------------------------------------
    // decoders
    //------------------------------------------------------------------
    function automatic logic [7:0] dnode_decode(input logic [3:0] code);
        logic [7:0] v;
        v = 8'h00;
        if (code == SMX_DCODE_CAL)
            v = 8'h01;
        else if (code >= SMX_DCODE_SW2 && code <= SMX_DCODE_SW8)
            v = 8'h01 << (code - 4'h1);
        else if (code == SMX_DCODE_ALL)
            v = 8'hff;
        // code 0 and 1010..1111 leave every D switch open
        return v;
    endfunction

    function automatic logic [6:0] pnode_decode(input logic [3:0] code);
        logic [6:0] v;
        v = 7'h00;
        if (code >= SMX_PCODE_SW5 && code <= SMX_PCODE_SW9)
            v = 7'h01 << (code - SMX_PCODE_SW5);
        else if (code == SMX_PCODE_SW11)
            v = 7'h20;
        else if (code == SMX_PCODE_LOOP_LO || code == SMX_PCODE_LOOP_HI)
            v = 7'h40;
        // 1111 and reserved codes open the whole group
        return v;
    endfunction

    //------------------------------------------------------------------
    // source selection
    //------------------------------------------------------------------
    wire logic [7:0] d_from_code;
    wire logic [6:0] p_from_code;
    wire logic [7:0] d_sel;
    wire logic [6:0] p_sel;

    assign d_from_code = dnode_decode(dnode_group_code);
    assign p_from_code = pnode_decode(pnode_group_code);
    assign d_sel = switch_source_select ?
        (d_individual & SMX_DFULL_MASK) : d_from_code;
    assign p_sel = switch_source_select ?
        p_individual : p_from_code;

    // registered so the analog switches never see decoder glitches
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dnode_switch_group <= smx_dsw_t'(dnode_decode(SMX_DCODE_RST));
            pnode_switch_group <= smx_psw_t'(pnode_decode(SMX_PCODE_RST));
        end
        else
        begin
            dnode_switch_group <= smx_dsw_t'(d_sel);
            pnode_switch_group <= smx_psw_t'(p_sel);
        end
    end

endmodule

// file: smx_switch_matrix.sv
// switch matrix D/P control registers behind an AXI4-Lite slave
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module smx_switch_matrix
    import smx_pkg::*;
#(
    parameter int ADDR_W = SMX_ADDR_W
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic [6:0] p_individual,
    output smx_dsw_t dnode_switch_group,
    output smx_psw_t pnode_switch_group
);

    //------------------------------------------------------------------
    // register state
    //------------------------------------------------------------------
    logic [3:0] dnode_group_code_r;
    logic [3:0] pnode_group_code_r;
    logic switch_source_select_r;
    logic [7:0] d_individual_r;

    //------------------------------------------------------------------
    // write channel holding
    //------------------------------------------------------------------
    // address and data may come in either order; each is held until
    // its partner arrives, so neither channel waits on the other
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    wire logic aw_take;
    wire logic w_take;
    wire logic aw_have;
    wire logic w_have;
    wire logic [ADDR_W-1:0] wr_addr;
    wire logic [31:0] wr_data;
    wire logic [3:0] wr_strb;
    wire logic wr_fire;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign aw_have = aw_held_r || aw_take;
    assign w_have = w_held_r || w_take;
    assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
    assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    assign wr_fire = aw_have && w_have && !bvalid_r;

    //------------------------------------------------------------------
    // write decode
    //------------------------------------------------------------------
    wire logic wr_group;
    wire logic wr_dfull;
    wire logic wr_mapped;

    assign wr_group = wr_fire && (wr_addr == SMX_OFS_GROUP);
    assign wr_dfull = wr_fire && (wr_addr == SMX_OFS_DFULL);
    assign wr_mapped = (wr_addr == SMX_OFS_GROUP) ||
        (wr_addr == SMX_OFS_DFULL);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            aw_held_r <= aw_have && !wr_fire;
            w_held_r <= w_have && !wr_fire;
            if (aw_take)
                aw_addr_r <= s_axi_awaddr;
            if (w_take)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    //------------------------------------------------------------------
    // write response
    //------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= SMX_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_mapped ? SMX_RESP_OKAY : SMX_RESP_DECERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    //------------------------------------------------------------------
    // grouped control register
    //------------------------------------------------------------------
    // T and N fields live in a neighbouring block; their bits read zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dnode_group_code_r <= SMX_DCODE_RST;
            pnode_group_code_r <= SMX_PCODE_RST;
            switch_source_select_r <= SMX_SRCSEL_RST;
        end
        else if (wr_group)
        begin
            if (wr_strb[0])
            begin
                dnode_group_code_r <=
                    wr_data[SMX_DCODE_LSB+:4];
                pnode_group_code_r <= wr_data[SMX_PCODE_LSB+:4];
            end
            if (wr_strb[SMX_SRCSEL_BIT/8])
                switch_source_select_r <=
                    wr_data[SMX_SRCSEL_BIT];
        end
    end

    //------------------------------------------------------------------
    // individual D register
    //------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            d_individual_r <= SMX_DFULL_RST;
        else if (wr_dfull && wr_strb[0])
            d_individual_r <= wr_data[7:0] & SMX_DFULL_MASK;
    end

    //------------------------------------------------------------------
    // read path
    //------------------------------------------------------------------
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    wire logic ar_take;
    wire logic rd_group;
    wire logic rd_dfull;
    wire logic [31:0] group_word;
    wire logic [31:0] dfull_word;
    wire logic [31:0] rd_word;

    assign s_axi_arready = !rvalid_r;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_group = (s_axi_araddr == SMX_OFS_GROUP);
    assign rd_dfull = (s_axi_araddr == SMX_OFS_DFULL);
    assign group_word = (32'(switch_source_select_r) << SMX_SRCSEL_BIT) |
        (32'(pnode_group_code_r) << SMX_PCODE_LSB) |
        (32'(dnode_group_code_r) << SMX_DCODE_LSB);
    assign dfull_word = {24'h00_0000, d_individual_r};
    assign rd_word = rd_group ? group_word :
        (rd_dfull ? dfull_word : 32'h0000_0000);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= SMX_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= (rd_group || rd_dfull) ? SMX_RESP_OKAY :
                SMX_RESP_DECERR;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    //------------------------------------------------------------------
    // switch drive
    //------------------------------------------------------------------
    smx_switch_drive u_drive
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .switch_source_select(switch_source_select_r),
        .dnode_group_code(dnode_group_code_r),
        .pnode_group_code(pnode_group_code_r),
        .d_individual(d_individual_r),
        .p_individual(p_individual),
        .dnode_switch_group(dnode_switch_group),
        .pnode_switch_group(pnode_switch_group)
    );

endmodule

// file: smx_switch_matrix_chk.sv
// assertion checker for the switch matrix register block
`timescale 1ns/1ps
module smx_switch_matrix_chk
    import smx_pkg::*;
#(
    parameter int ADDR_W = SMX_ADDR_W
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire smx_dsw_t dnode_switch_group,
    input wire smx_psw_t pnode_switch_group
);
    //------------------------------------------------------------------
    // read address tracking and properties
    //------------------------------------------------------------------
    logic [ADDR_W-1:0] rd_addr_r;
    wire logic rd_group = rd_addr_r == SMX_OFS_GROUP;
    wire logic rd_dfull = rd_addr_r == SMX_OFS_DFULL;

    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rd_addr_r <= s_axi_araddr;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_reset_clear: assert property ($rose(aresetn) |->
        dnode_switch_group == 8'h00 && pnode_switch_group == 7'h00
        && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not reset");
    // six has no individual bit, so only group codes can close it
    a_six_grouped: assert property (dnode_switch_group.six |->
        dnode_switch_group inside {8'hff, 8'h20}) else $error("six alone");
    a_dsw_cause: assert property ($changed(dnode_switch_group)
        && $past(aresetn) && $past(aresetn, 2) |->
        $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
        else $error("d switches moved without a write");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_write_busy: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    a_read_turn: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read late");
    a_dreg_reserved: assert property (s_axi_rvalid && rd_dfull |->
        s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[5]
        && s_axi_rresp == SMX_RESP_OKAY) else $error("d reg reserved bits");
    a_group_reserved: assert property (s_axi_rvalid && rd_group |->
        s_axi_rdata[31:17] == 15'h0 && s_axi_rdata[15:8] == 8'h00)
        else $error("group reg reserved bits");
    a_unmapped_rd: assert property (s_axi_rvalid && !rd_group &&
        !rd_dfull |-> s_axi_rdata == 32'h0 && s_axi_rresp == SMX_RESP_DECERR)
        else $error("unmapped read answer");

    c_write_err: cover property (s_axi_bvalid &&
        s_axi_bresp == SMX_RESP_DECERR);
    c_read_dfull: cover property (s_axi_rvalid && rd_dfull);
    c_all_closed: cover property (dnode_switch_group == 8'hff);
endmodule

bind smx_switch_matrix smx_switch_matrix_chk #(.ADDR_W(ADDR_W))
    smx_switch_matrix_chk_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata,
    .s_axi_rresp, .dnode_switch_group, .pnode_switch_group);

// file: switch_matrix_d_p_control_tb_top.sv
// self-checking bench for the switch matrix register block
`timescale 1ns/1ps
module switch_matrix_d_p_control_tb_top
    import smx_pkg::*;
;
    //------------------------------------------------------------------
    // stimulus, bus tasks and sequence
    //------------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [6:0] p_individual = 7'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    smx_dsw_t dnode_switch_group;
    smx_psw_t pnode_switch_group;
    int num_errors = 0;
    int num_checks = 0;

    smx_switch_matrix smx_switch_matrix_i (.aclk, .aresetn, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .p_individual, .dnode_switch_group,
        .pnode_switch_group);

    initial
    begin
        forever #2 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // every bus wait is bounded; a stuck slave ends the run here
    task automatic tick(inout int n);
        n++;
        if (n > 40)
        begin
            num_errors++;
            $display("[FAIL] %0t bus wait timed out", $time);
            give_verdict();
        end
    endtask

    // ready is combinational and inputs move only at rising edges, so the
    // level seen at the falling edge tells whether the next edge takes it
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        logic aw, w, ta, tw;
        logic [1:0] r;
        n = 0;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w)
        begin
            @(negedge aclk);
            ta = aw && s_axi_awready;
            tw = w && s_axi_wready;
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            aw = aw && !ta;
            w = w && !tw;
            tick(n);
        end
        do
        begin
            @(negedge aclk);
            ta = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            tick(n);
        end
        while (!ta);
        check(32'(r), 32'(er));
    endtask

    task automatic axi_rd(input logic [15:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        int n;
        logic t;
        logic [31:0] d;
        logic [1:0] r;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            t = s_axi_arready;
            @(posedge aclk);
            tick(n);
        end
        while (!t);
        s_axi_arvalid <= 1'b0;
        do
        begin
            @(negedge aclk);
            t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            tick(n);
        end
        while (!t);
        check(d, ed);
        check(32'(r), 32'(er));
    endtask

    task automatic expect_sw(input logic [7:0] de, input logic [6:0] pe);
        @(negedge aclk);
        check(32'(dnode_switch_group), 32'(de));
        check(32'(pnode_switch_group), 32'(pe));
        @(posedge aclk);
    endtask

    function automatic logic [7:0] d_exp(input logic [3:0] c);
        if (c == 4'h9)
            return 8'hff;
        if (c == 4'h0 || c > 4'h9)
            return 8'h00;
        return 8'h01 << (c - 4'h1);
    endfunction

    function automatic logic [6:0] p_exp(input logic [3:0] c);
        if (c >= 4'h5 && c <= 4'h9)
            return 7'h01 << (c - 4'h5);
        if (c == 4'hb)
            return 7'h20;
        if (c == 4'hd || c == 4'he)
            return 7'h40;
        return 7'h00;
    endfunction

    function automatic logic [31:0] grp(input logic s, input logic [3:0] p,
        input logic [3:0] d);
        return {15'h0, s, 8'h00, p, d};
    endfunction

    initial
    begin
        logic [3:0] pc;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_wr(16'h2148, 32'hffff_ffff, SMX_RESP_DECERR);
        expect_sw(8'h00, 7'h00);
        axi_rd(SMX_OFS_GROUP, 32'h0000_00ff, SMX_RESP_OKAY);
        axi_rd(SMX_OFS_DFULL, 32'h0, SMX_RESP_OKAY);
        axi_rd(16'h2144, 32'h0, SMX_RESP_DECERR);
        p_individual <= 7'h55;
        // p codes 1010 and 1100 are written as all-open 1111 instead
        for (int c = 0; c < 16; c++)
        begin
            pc = (c == 10 || c == 12) ? 4'hf : 4'(c);
            axi_wr(SMX_OFS_GROUP, grp(1'b0, pc, 4'(c)),
                SMX_RESP_OKAY);
            expect_sw(d_exp(4'(c)),
                p_exp(pc));
            axi_rd(SMX_OFS_GROUP, grp(1'b0, pc, 4'(c)),
                SMX_RESP_OKAY);
        end
        axi_wr(SMX_OFS_DFULL, 32'hffff_ffff, SMX_RESP_OKAY);
        axi_rd(SMX_OFS_DFULL, 32'h0000_00df, SMX_RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        axi_wr(SMX_OFS_GROUP, grp(1'b1, 4'h0, 4'h0),
            SMX_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        expect_sw(8'h00, 7'h00);
        axi_rd(SMX_OFS_GROUP, 32'h0, SMX_RESP_OKAY);
        axi_wr(SMX_OFS_GROUP, grp(1'b1, 4'h9, 4'h9),
            SMX_RESP_OKAY);
        expect_sw(8'hdf, 7'h55);
        p_individual <= 7'h2a;
        expect_sw(8'hdf, 7'h55);
        expect_sw(8'hdf, 7'h2a);
        for (int b = 0; b < 8; b++)
        begin
            axi_wr(SMX_OFS_DFULL, 32'h1 << b, SMX_RESP_OKAY);
            expect_sw((b == 5) ? 8'h00 : 8'h01 << b,
                7'h2a);
        end
        axi_wr(SMX_OFS_GROUP, grp(1'b0, 4'hf, 4'h9),
            SMX_RESP_OKAY);
        expect_sw(8'hff, 7'h00);
        give_verdict();
    end
endmodule
